// ==== hdl/fws_pkg.sv ====
// Shared constants and types of the flash status polling controller.
package fws_pkg;
  // ----------------------------------------------------------------
  // Flash bus widths and status bit positions
  // ----------------------------------------------------------------
  localparam int FL_ADDR_W   = 20;
  localparam int FL_DATA_W   = 16;
  localparam int DQ_POLL     = 7;
  localparam int DQ_TOG1     = 6;
  localparam int DQ_TMO      = 5;
  localparam int DQ_ETMR     = 3;
  localparam int DQ_TOG2     = 2;
  localparam logic [15:0] RESET_CMD = 16'h00F0;
  // ----------------------------------------------------------------
  // Register offsets and fields
  // ----------------------------------------------------------------
  localparam int AXI_AW      = 5;
  localparam logic [4:0] OFF_CMD   = 5'h00;
  localparam logic [4:0] OFF_ADDR  = 5'h04;
  localparam logic [4:0] OFF_WDATA = 5'h08;
  localparam logic [4:0] OFF_STAT  = 5'h0C;
  localparam logic [4:0] OFF_RDATA = 5'h10;
  localparam int CMD_OP_LSB  = 0;
  localparam int STAT_BUSY   = 0;
  localparam int STAT_DONE   = 1;
  localparam int STAT_FAIL   = 2;
  localparam int STAT_RST    = 3;
  localparam int STAT_RYBY   = 4;
  localparam int STAT_ETMR   = 5;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ----------------------------------------------------------------
  // Timing, in nanoseconds and in MCLK cycles
  // ----------------------------------------------------------------
  localparam int CLK_NS      = 25;
  localparam int T_RC_NS     = 70;
  localparam int T_WP_NS     = 100;
  localparam int T_OEH_NS    = 10;
  localparam int RC_CYC      = (T_RC_NS + CLK_NS - 1) / CLK_NS;
  localparam int WP_CYC      = (T_WP_NS + CLK_NS - 1) / CLK_NS;
  localparam int GAP_CYC     = (T_OEH_NS + CLK_NS - 1) / CLK_NS;
  // ----------------------------------------------------------------
  // Operations started through the command register
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {OP_WRITE, OP_READ, OP_DPOLL, OP_TPOLL} fws_op_t;
endpackage : fws_pkg

// ==== hdl/fws_cycle.sv ====
// Single flash bus cycle engine: one read or one write strobe.
`timescale 1ns/1ps
module fws_cycle #(
  parameter int ADDR_W = fws_pkg::FL_ADDR_W,
  parameter int DATA_W = fws_pkg::FL_DATA_W,
  parameter int RC     = fws_pkg::RC_CYC,
  parameter int WP     = fws_pkg::WP_CYC,
  parameter int GAP    = fws_pkg::GAP_CYC
) (
  // Clock and control
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              en,
  // Request and answer
  input  wire logic              start,
  input  wire logic              write,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  output logic                   done,
  output logic [DATA_W-1:0]      rdata,
  // Flash pins
  output logic [ADDR_W-1:0]      fl_addr,
  input  wire logic [DATA_W-1:0] fl_dq_i,
  output logic [DATA_W-1:0]      fl_dq_o,
  output logic                   fl_dq_oe,
  output logic                   fl_ce_n,
  output logic                   fl_oe_n,
  output logic                   fl_we_n
);
  initial begin
    if (RC < 1 || WP < 1 || GAP < 1 || RC > 255 || WP > 255 || GAP > 255)
      $error("fws_cycle: strobe counts must lie in 1..255");
  end

  typedef enum logic [1:0] {PH_IDLE, PH_SETUP, PH_STROBE, PH_GAP} fws_ph_t;
  typedef struct packed {
    fws_ph_t           ph;
    logic [7:0]        cnt;
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic              done;
    logic              ce_n;
    logic              oe_n;
    logic              we_n;
    logic              dq_oe;
  } fws_cyc_t;

  fws_cyc_t s;
  fws_cyc_t next_s;

  always_comb begin
    next_s      = s;
    next_s.done = 1'b0;
    case (s.ph)
      PH_IDLE: begin
        if (start) begin
          next_s.write = write;
          next_s.addr  = addr;
          next_s.wdata = wdata;
          next_s.ce_n  = 1'b0;
          next_s.dq_oe = write;
          next_s.ph    = PH_SETUP;
        end
      end
      PH_SETUP: begin
        next_s.we_n = ~s.write;
        next_s.oe_n = s.write;
        next_s.cnt  = s.write ? 8'(WP - 1) : 8'(RC - 1);
        next_s.ph   = PH_STROBE;
      end
      PH_STROBE: begin
        if (s.cnt == 8'h00) begin
          if (!s.write) begin
            next_s.rdata = fl_dq_i;
          end
          next_s.we_n = 1'b1;
          next_s.oe_n = 1'b1;
          next_s.cnt  = 8'(GAP - 1);
          next_s.ph   = PH_GAP;
        end else begin
          next_s.cnt = s.cnt - 8'h01;
        end
      end
      PH_GAP: begin
        // Chip enable and data drive stay one edge past the strobe for hold time.
        next_s.ce_n  = 1'b1;
        next_s.dq_oe = 1'b0;
        if (s.cnt == 8'h00) begin
          next_s.done = 1'b1;
          next_s.ph   = PH_IDLE;
        end else begin
          next_s.cnt = s.cnt - 8'h01;
        end
      end
      default: next_s.ph = PH_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '{ph: PH_IDLE, cnt: 8'h00, write: 1'b0, addr: '0, wdata: '0, rdata: '0,
             done: 1'b0, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, dq_oe: 1'b0};
    end else if (en) begin
      s <= next_s;
    end
  end

  assign done     = s.done;
  assign rdata    = s.rdata;
  assign fl_addr  = s.addr;
  assign fl_dq_o  = s.wdata;
  assign fl_dq_oe = s.dq_oe;
  assign fl_ce_n  = s.ce_n;
  assign fl_oe_n  = s.oe_n;
  assign fl_we_n  = s.we_n;
endmodule : fws_cycle

// ==== hdl/fws_host.sv ====
// Host controller that runs flash bus cycles and status polling for software.
//
// Function
// - After timeout failure, host writes reset command.
// - Host may skip timer only with short gaps.
// - Host reads twice, rechecks when timeout bit high.
// - Host rechecks polling bit despite timeout bit high.
// - Host polls at a valid status address.
`timescale 1ns/1ps
module fws_host #(
  parameter int ADDR_W = fws_pkg::FL_ADDR_W,
  parameter int DATA_W = fws_pkg::FL_DATA_W
) (
  // Clock, reset and enable
  input  wire logic              MCLK,
  input  wire logic              RST_N,
  input  wire logic              CLK_EN,
  // AXI4-Lite write channels
  input  wire logic [4:0]        AWADDR,
  input  wire logic              AWVALID,
  output logic                   AWREADY,
  input  wire logic [31:0]       WDATA,
  input  wire logic [3:0]        WSTRB,
  input  wire logic              WVALID,
  output logic                   WREADY,
  output logic [1:0]             BRESP,
  output logic                   BVALID,
  input  wire logic              BREADY,
  // AXI4-Lite read channels
  input  wire logic [4:0]        ARADDR,
  input  wire logic              ARVALID,
  output logic                   ARREADY,
  output logic [31:0]            RDATA,
  output logic [1:0]             RRESP,
  output logic                   RVALID,
  input  wire logic              RREADY,
  // Flash pins
  output logic [ADDR_W-1:0]      FL_ADDR,
  input  wire logic [DATA_W-1:0] FL_DQ_I,
  output logic [DATA_W-1:0]      FL_DQ_O,
  output logic                   FL_DQ_OE,
  output logic                   FL_CE_N,
  output logic                   FL_OE_N,
  output logic                   FL_WE_N,
  input  wire logic              FL_READY_BUSY
);
  initial begin
    if (ADDR_W < 1 || ADDR_W > 32 || DATA_W < 8 || DATA_W > 32)
      $error("fws_host: flash widths out of range");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {S_IDLE, S_WAIT} fws_st_t;
  typedef struct packed {
    logic              aw_got;
    logic [4:0]        aw_addr;
    logic              w_got;
    logic [31:0]       w_data;
    logic [3:0]        w_strb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
    logic              awready;
    logic              wready;
    logic              arready;
    fws_pkg::fws_op_t  op;
    logic [31:0]       addr;
    logic [31:0]       wdata;
    logic [DATA_W-1:0] last;
    logic [DATA_W-1:0] first;
    logic              have_first;
    logic              check5;
    logic              resetting;
    logic              busy;
    logic              done;
    logic              fail;
    logic              rst_sent;
    logic              ryby;
    fws_st_t           st;
    logic              cyc_start;
    logic              cyc_write;
    logic [DATA_W-1:0] cyc_data;
  } fws_host_t;

  fws_host_t         s;
  fws_host_t         next_s;
  logic              eng_done;
  logic [DATA_W-1:0] eng_rdata;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) r[i*8 +: 8] = nw[i*8 +: 8];
    end
    return r;
  endfunction : merge

  function automatic logic is_mapped(input logic [4:0] a);
    return a == fws_pkg::OFF_CMD || a == fws_pkg::OFF_ADDR || a == fws_pkg::OFF_WDATA ||
           a == fws_pkg::OFF_STAT || a == fws_pkg::OFF_RDATA;
  endfunction : is_mapped

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [31:0] stat;
    logic        go;
    next_s           = s;
    stat             = '0;
    go               = 1'b0;
    next_s.cyc_start = 1'b0;
    next_s.ryby      = FL_READY_BUSY;
    // Write channels: address and data taken in either order.
    if (AWVALID && !s.aw_got && !s.bvalid) begin
      next_s.aw_got  = 1'b1;
      next_s.aw_addr = AWADDR;
    end
    if (WVALID && !s.w_got && !s.bvalid) begin
      next_s.w_got  = 1'b1;
      next_s.w_data = WDATA;
      next_s.w_strb = WSTRB;
    end
    if (s.bvalid && BREADY) next_s.bvalid = 1'b0;
    if (s.aw_got && s.w_got && !s.bvalid) begin
      next_s.aw_got = 1'b0;
      next_s.w_got  = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp  = is_mapped(s.aw_addr) ? fws_pkg::RESP_OKAY : fws_pkg::RESP_SLVERR;
      case (s.aw_addr)
        fws_pkg::OFF_CMD: go = s.w_strb[0] && !s.busy;
        fws_pkg::OFF_ADDR: next_s.addr = merge(s.addr, s.w_data, s.w_strb);
        fws_pkg::OFF_WDATA: next_s.wdata = merge(s.wdata, s.w_data, s.w_strb);
        fws_pkg::OFF_STAT: begin
          if (s.w_strb[0] && s.w_data[fws_pkg::STAT_DONE]) next_s.done = 1'b0;
          if (s.w_strb[0] && s.w_data[fws_pkg::STAT_FAIL]) next_s.fail = 1'b0;
          if (s.w_strb[0] && s.w_data[fws_pkg::STAT_RST]) next_s.rst_sent = 1'b0;
        end
        default: ;
      endcase
    end
    // Read channels.
    stat[fws_pkg::STAT_BUSY] = s.busy;
    stat[fws_pkg::STAT_DONE] = s.done;
    stat[fws_pkg::STAT_FAIL] = s.fail;
    stat[fws_pkg::STAT_RST]  = s.rst_sent;
    stat[fws_pkg::STAT_RYBY] = s.ryby;
    stat[fws_pkg::STAT_ETMR] = s.last[fws_pkg::DQ_ETMR];
    if (s.rvalid && RREADY) next_s.rvalid = 1'b0;
    if (ARVALID && !s.rvalid) begin
      next_s.rvalid = 1'b1;
      next_s.rresp  = is_mapped(ARADDR) ? fws_pkg::RESP_OKAY : fws_pkg::RESP_SLVERR;
      case (ARADDR)
        fws_pkg::OFF_CMD: next_s.rdata = {30'h0, s.op};
        fws_pkg::OFF_ADDR: next_s.rdata = s.addr;
        fws_pkg::OFF_WDATA: next_s.rdata = s.wdata;
        fws_pkg::OFF_STAT: next_s.rdata = stat;
        fws_pkg::OFF_RDATA: next_s.rdata = 32'(s.last);
        default: next_s.rdata = 32'h0000_0000;
      endcase
    end
    // ----------------------------------------------------------------
    // Operation sequencer
    // ----------------------------------------------------------------
    case (s.st)
      S_IDLE: begin
        if (go) begin
          next_s.op         = fws_pkg::fws_op_t'(s.w_data[fws_pkg::CMD_OP_LSB +: 2]);
          next_s.busy       = 1'b1;
          next_s.have_first = 1'b0;
          next_s.check5     = 1'b0;
          next_s.resetting  = 1'b0;
          next_s.cyc_start  = 1'b1;
          next_s.cyc_write  = (s.w_data[fws_pkg::CMD_OP_LSB +: 2] == 2'h0);
          next_s.cyc_data   = s.wdata[DATA_W-1:0];
          next_s.st         = S_WAIT;
        end
      end
      S_WAIT: begin
        // Each poll read starts only after the previous cycle closed its strobe.
        if (eng_done) begin
          next_s.last      = s.cyc_write ? s.last : eng_rdata;
          next_s.cyc_write = 1'b0;
          next_s.cyc_start = 1'b1;
          if (s.resetting || s.op == fws_pkg::OP_WRITE || s.op == fws_pkg::OP_READ) begin
            next_s.cyc_start = 1'b0;
            next_s.busy      = 1'b0;
            next_s.done      = 1'b1;
            next_s.st        = S_IDLE;
          end else if (s.op == fws_pkg::OP_DPOLL) begin
            if (eng_rdata[fws_pkg::DQ_POLL] == s.wdata[fws_pkg::DQ_POLL]) begin
              next_s.cyc_start = 1'b0;
              next_s.busy      = 1'b0;
              next_s.done      = 1'b1;
              next_s.st        = S_IDLE;
            end else if (s.check5) begin
              next_s.fail      = 1'b1;
              next_s.resetting = 1'b1;
            end else if (eng_rdata[fws_pkg::DQ_TMO]) begin
              next_s.check5 = 1'b1;
            end
          end else if (!s.have_first) begin
            next_s.first      = eng_rdata;
            next_s.have_first = 1'b1;
          end else if (eng_rdata[fws_pkg::DQ_TOG1] == s.first[fws_pkg::DQ_TOG1]) begin
            next_s.cyc_start = 1'b0;
            next_s.busy      = 1'b0;
            next_s.done      = 1'b1;
            next_s.st        = S_IDLE;
          end else if (s.check5) begin
            next_s.fail      = 1'b1;
            next_s.resetting = 1'b1;
          end else if (eng_rdata[fws_pkg::DQ_TMO]) begin
            next_s.check5     = 1'b1;
            next_s.have_first = 1'b0;
          end else begin
            next_s.first = eng_rdata;
          end
          if (next_s.resetting && !s.resetting) begin
            next_s.cyc_write = 1'b1;
            next_s.cyc_data  = DATA_W'(fws_pkg::RESET_CMD);
            next_s.rst_sent  = 1'b1;
          end
        end
      end
      default: next_s.st = S_IDLE;
    endcase
    // Ready flags are registered so every bus output comes from a flop.
    next_s.awready = ~next_s.aw_got & ~next_s.bvalid;
    next_s.wready  = ~next_s.w_got & ~next_s.bvalid;
    next_s.arready = ~next_s.rvalid;
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      s <= '{st: S_IDLE, op: fws_pkg::OP_WRITE, ryby: 1'b1, awready: 1'b1, wready: 1'b1,
             arready: 1'b1, default: '0};
    end else if (CLK_EN) begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // Flash cycle engine
  // ----------------------------------------------------------------
  fws_cycle #(
    .ADDR_W (ADDR_W),
    .DATA_W (DATA_W)
  ) u_cycle (
    .clk      (MCLK),
    .rst_n    (RST_N),
    .en       (CLK_EN),
    .start    (s.cyc_start),
    .write    (s.cyc_write),
    .addr     (s.addr[ADDR_W-1:0]),
    .wdata    (s.cyc_data),
    .done     (eng_done),
    .rdata    (eng_rdata),
    .fl_addr  (FL_ADDR),
    .fl_dq_i  (FL_DQ_I),
    .fl_dq_o  (FL_DQ_O),
    .fl_dq_oe (FL_DQ_OE),
    .fl_ce_n  (FL_CE_N),
    .fl_oe_n  (FL_OE_N),
    .fl_we_n  (FL_WE_N)
  );

  assign AWREADY = s.awready;
  assign WREADY  = s.wready;
  assign BVALID  = s.bvalid;
  assign BRESP   = s.bresp;
  assign ARREADY = s.arready;
  assign RVALID  = s.rvalid;
  assign RDATA   = s.rdata;
  assign RRESP   = s.rresp;
endmodule : fws_host

// ==== verif/fws_host_monitor.sv ====
// Concurrent checks on the ports of the flash status host.
`timescale 1ns/1ps
module fws_host_monitor #(
  parameter int ADDR_W = 20
) (
  // Clock and reset
  input wire logic              MCLK,
  input wire logic              RST_N,
  // Register bus
  input wire logic              ARVALID,
  input wire logic              ARREADY,
  input wire logic              RVALID,
  input wire logic              RREADY,
  input wire logic [31:0]       RDATA,
  input wire logic              BVALID,
  input wire logic              BREADY,
  input wire logic [1:0]        BRESP,
  // Flash pins
  input wire logic [ADDR_W-1:0] FL_ADDR,
  input wire logic              FL_DQ_OE,
  input wire logic              FL_CE_N,
  input wire logic              FL_OE_N,
  input wire logic              FL_WE_N
);
  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  a_bresp_held: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
    else $error("write response dropped early");
  a_rdata_held: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
    else $error("read data dropped early");
  a_read_answer: assert property (ARVALID && ARREADY |=> RVALID)
    else $error("read answer late");
  a_strobe_excl: assert property (!(!FL_OE_N && !FL_WE_N))
    else $error("read and write strobes together");
  a_strobe_framed: assert property (!FL_OE_N || !FL_WE_N |-> !FL_CE_N)
    else $error("strobe without chip enable");
  a_read_width: assert property ($fell(FL_OE_N) |=> !FL_OE_N [*2] ##1 FL_OE_N)
    else $error("read strobe width wrong");
  a_write_width: assert property ($fell(FL_WE_N) |=> !FL_WE_N [*3] ##1 FL_WE_N)
    else $error("write strobe width wrong");
  a_addr_steady: assert property (!FL_CE_N && !$past(FL_CE_N) |-> $stable(FL_ADDR))
    else $error("address moved inside a cycle");
  a_read_no_drive: assert property (!FL_OE_N |-> !FL_DQ_OE)
    else $error("host drives data during a read");
  a_write_drives: assert property (!FL_WE_N |-> FL_DQ_OE)
    else $error("write strobe without data driven");
  c_write_pulse: cover property ($rose(FL_WE_N));
  c_read_pulse: cover property ($rose(FL_OE_N));
  c_bus_error: cover property (BVALID && BRESP == 2'h2);
endmodule : fws_host_monitor
bind fws_host fws_host_monitor #(.ADDR_W(ADDR_W)) mon (.MCLK(MCLK), .RST_N(RST_N),
  .ARVALID(ARVALID), .ARREADY(ARREADY), .RVALID(RVALID), .RREADY(RREADY), .RDATA(RDATA),
  .BVALID(BVALID), .BREADY(BREADY), .BRESP(BRESP), .FL_ADDR(FL_ADDR), .FL_DQ_OE(FL_DQ_OE),
  .FL_CE_N(FL_CE_N), .FL_OE_N(FL_OE_N), .FL_WE_N(FL_WE_N));

// ==== verif/fws_flash_model.sv ====
// Behavioural flash device that reports program and erase status on its data pins.
`timescale 1ns/1ps
module fws_flash_model #(
  parameter int         T_PROG   = 2000,
  parameter int         T_FAIL   = 4000,
  parameter int         T_ETMR   = 10000,
  parameter int         T_ERASE  = 20000,
  parameter int         T_PROT   = 2000,
  parameter logic [4:0] PROT_SEC = 5'h1F
) (
  // Bus from the host
  input  wire logic [19:0] addr,
  input  wire logic [15:0] din,
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  // Answer to the host
  output logic [15:0]      dq,
  output logic             ready_busy_pin
);
  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  logic [15:0] mem [int];
  logic [15:0] pd = 16'h0000;
  logic [19:0] pa = 20'h00000;
  logic [31:0] esel = 32'h00000000;
  logic        busy = 1'b0, ers = 1'b0, tmr = 1'b0, tmo = 1'b0, hang = 1'b0;
  logic        tog1 = 1'b0, tog2 = 1'b0, armp = 1'b0, arme = 1'b0;
  realtime     t_end = 0.0;
  initial dq = 16'h0000;
  function automatic logic [15:0] rd(input logic [19:0] a);
    return mem.exists(a) ? mem[a] : 16'hFFFF;
  endfunction : rd
  task automatic idle();
    busy = 1'b0;
    ers = 1'b0;
    tmr = 1'b0;
    tmo = 1'b0;
    hang = 1'b0;
    armp = 1'b0;
    arme = 1'b0;
    esel = 32'h00000000;
  endtask : idle
  // Open drain with pull-up, so a released pin reads high.
  assign ready_busy_pin = !busy;
  // Commands take effect at the rising write strobe.
  always @(posedge we_n) begin
    if (din === 16'h00F0 && !(ers && tmr)) begin
      idle();
    end else if (ers && tmr && din !== 16'h00B0) begin
    end else if (armp) begin
      armp = 1'b0;
      pa = addr;
      pd = din;
      busy = 1'b1;
      hang = (addr[19:15] != PROT_SEC) && (|(din & ~rd(addr)));
      t_end = $realtime + (addr[19:15] == PROT_SEC ? T_PROT : hang ? T_FAIL : T_PROG);
    end else if (arme && din === 16'h0030) begin
      esel[addr[19:15]] = 1'b1;
      busy = 1'b1;
      ers = 1'b1;
      t_end = $realtime + T_ETMR;
    end else if (arme && din === 16'h0010) begin
      esel = 32'hFFFFFFFF;
      busy = 1'b1;
      ers = 1'b1;
      tmr = 1'b1;
      t_end = $realtime + T_ERASE;
    end else begin
      armp = (din === 16'h00A0);
      arme = arme || (din === 16'h0080);
    end
  end
  always #50 begin
    if (busy && $realtime >= t_end) begin
      if (ers && !tmr) begin
        tmr = 1'b1;
        t_end = $realtime + T_ERASE;
      end else if (hang) begin
        tmo = 1'b1;
      end else begin
        foreach (mem[k]) begin
          if (ers && esel[k[19:15]] && k[19:15] != PROT_SEC) mem[k] = 16'hFFFF;
        end
        if (!ers && pa[19:15] != PROT_SEC) mem[pa] = pd;
        idle();
      end
    end
  end
  always @(negedge oe_n) begin
    if (!ce_n && busy) begin
      dq = {8'h00, (ers ? 1'b0 : ~pd[7]), tog1, tmo, 1'b0, ers & tmr, ers & tog2, 2'b00};
    end else if (!ce_n) begin
      dq = rd(addr);
    end
  end
  // A released bus shows the inverse of the last value, never a stale copy.
  always @(posedge oe_n) begin
    dq = ~dq;
    tog1 = tog1 ^ busy;
    tog2 = tog2 ^ (busy && ers && esel[addr[19:15]]);
  end
endmodule : fws_flash_model

// ==== verif/test_fws_host.sv ====
// Self-checking bench for the flash status host with a behavioural flash.
`timescale 1ns/1ps
module test_fws_host;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic        mclk, rst_n, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, fde, ce, oe, we, rb;
  logic [4:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, v;
  logic [1:0]  bresp, rresp, r;
  logic [19:0] fa;
  logic [15:0] fdi, fdo, s1;
  int          bad_count, samples_checked, cyc;
  fws_host uut (.MCLK(mclk), .RST_N(rst_n), .CLK_EN(1'b1), .AWADDR(awaddr), .AWVALID(awvalid),
    .AWREADY(awready), .WDATA(wdata), .WSTRB(4'hF), .WVALID(wvalid), .WREADY(wready),
    .BRESP(bresp), .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
    .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
    .FL_ADDR(fa), .FL_DQ_I(fdi), .FL_DQ_O(fdo), .FL_DQ_OE(fde), .FL_CE_N(ce), .FL_OE_N(oe),
    .FL_WE_N(we), .FL_READY_BUSY(rb));
  fws_flash_model flash (.addr(fa), .din(fdo), .ce_n(ce), .oe_n(oe), .we_n(we), .dq(fdi),
    .ready_busy_pin(rb));
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic axi_wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] e);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid && bready));
    bready <= 1'b0;
    chk("write response", bresp, e);
    @(posedge mclk);
  endtask : axi_wr
  task automatic axi_rd(input logic [4:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid && rready));
    v = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge mclk);
  endtask : axi_rd
  task automatic fop(input fws_pkg::fws_op_t op, input logic [19:0] a, input logic [15:0] d);
    axi_wr(fws_pkg::OFF_STAT, 32'h0000000E, fws_pkg::RESP_OKAY);
    axi_wr(fws_pkg::OFF_ADDR, {12'h000, a}, fws_pkg::RESP_OKAY);
    axi_wr(fws_pkg::OFF_WDATA, {16'h0000, d}, fws_pkg::RESP_OKAY);
    axi_wr(fws_pkg::OFF_CMD, {30'h00000000, op}, fws_pkg::RESP_OKAY);
    v = 32'h00000000;
    while (v[fws_pkg::STAT_DONE] !== 1'b1) axi_rd(fws_pkg::OFF_STAT);
  endtask : fop
  task automatic rda(input logic [19:0] a);
    fop(fws_pkg::OP_READ, a, 16'h0000);
    axi_rd(fws_pkg::OFF_RDATA);
  endtask : rda
  task automatic unl();
    fop(fws_pkg::OP_WRITE, 20'h00555, 16'h00AA);
    fop(fws_pkg::OP_WRITE, 20'h002AA, 16'h0055);
  endtask : unl
  task automatic seq(input logic [15:0] c, input logic [19:0] a, input logic [15:0] d);
    unl();
    fop(fws_pkg::OP_WRITE, 20'h00555, c);
    if (c == 16'h0080) unl();
    fop(fws_pkg::OP_WRITE, a, d);
  endtask : seq
  // ------------------------------------------------------------
  // Clock, timeout and tests
  // ------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 30000) begin
      bad_count++;
      report_and_stop();
    end
  end
  initial begin
    {rst_n, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    axi_rd(fws_pkg::OFF_STAT);
    chk("status at reset", v, 32'h00000010);
    axi_rd(5'h14);
    chk("unmapped read", {r, v[29:0]}, {fws_pkg::RESP_SLVERR, 30'h00000000});
    axi_wr(5'h18, 32'h00000001, fws_pkg::RESP_SLVERR);
    $display("test registers finished");
    seq(16'h00A0, 20'h00100, 16'h1234);
    axi_rd(fws_pkg::OFF_STAT);
    chk("ready pin while busy", v[4], 1'b0);
    fop(fws_pkg::OP_DPOLL, 20'h00100, 16'h1234);
    chk("data poll status", v[4:0], 5'h12);
    rda(20'h00100);
    chk("programmed word", v, 32'h00001234);
    seq(16'h00A0, 20'h10200, 16'h0055);
    fop(fws_pkg::OP_TPOLL, 20'h7FFFF, 16'h0000);
    chk("toggle poll status", v[4:0], 5'h12);
    $display("test program finished");
    seq(16'h00A0, 20'h00100, 16'hFFFF);
    fop(fws_pkg::OP_TPOLL, 20'h00100, 16'h0000);
    chk("toggle poll failure", v[4:0], 5'h1E);
    rda(20'h00100);
    chk("word kept after failure", v, 32'h00001234);
    seq(16'h00A0, 20'h10200, 16'h00FF);
    fop(fws_pkg::OP_DPOLL, 20'h10200, 16'h00FF);
    chk("data poll failure", v[4:0], 5'h1E);
    seq(16'h00A0, 20'hF8000, 16'h00AA);
    fop(fws_pkg::OP_DPOLL, 20'hF8000, 16'h00AA);
    chk("protected poll status", v[4:0], 5'h12);
    rda(20'hF8000);
    chk("protected word", v, 32'h0000FFFF);
    $display("test failures finished");
    seq(16'h0080, 20'h00100, 16'h0030);
    rda(20'h00100);
    chk("timer open", {v[7], v[3]}, 2'b00);
    unl();
    fop(fws_pkg::OP_WRITE, 20'h08000, 16'h0030);
    rda(20'h00100);
    while (v[3] !== 1'b1) rda(20'h00100);
    s1 = v[15:0];
    rda(20'h08004);
    chk("first toggle pair", v[6] ^ s1[6], 1'b1);
    chk("second toggle pair", v[2] ^ s1[2], 1'b1);
    fop(fws_pkg::OP_WRITE, 20'h00000, 16'h00F0);
    rda(20'h00100);
    chk("command ignored", {v[7], v[3]}, 2'b01);
    fop(fws_pkg::OP_TPOLL, 20'h00100, 16'h0000);
    chk("erase poll status", v[4:0], 5'h12);
    rda(20'h00100);
    chk("erased word", v, 32'h0000FFFF);
    rda(20'h10200);
    chk("unselected word", v, 32'h00000055);
    seq(16'h0080, 20'h00555, 16'h0010);
    rda(20'h10200);
    chk("chip erase timer", v[3], 1'b1);
    fop(fws_pkg::OP_DPOLL, 20'h10200, 16'h0080);
    chk("chip erase poll", v[4:0], 5'h12);
    rda(20'h10200);
    chk("chip erased word", v, 32'h0000FFFF);
    $display("test erase finished");
    report_and_stop();
  end
endmodule : test_fws_host
